// ---- rtl/acm_pkg.sv ----
// constants and carrier types for the ata command handler
// Notes on behaviour
// R1 - set-multiple command raises busy, then inspects the transfer count register
// R2 - a supported nonzero block count is stored and multi-sector commands enabled
// R3 - an unsupported block count aborts the command and disables multi-sector commands
// R4 - set-multiple with a count of zero disables multi-sector commands
// R5 - multi-sector commands start out disabled after power-on
// R6 - identification word 82 bit 0 reports self-monitoring support
// R7 - standby raises busy, enters sleep, drops busy, interrupts at once
// R8 - standby immediate raises busy, enters sleep, drops busy, interrupts at once
// R9 - any new command wakes the drive; the host wakes it by issuing one
// R10 - translate sector only completes and returns zero in the transfer count
// R11 - write buffer takes exactly 512 bytes into the sector buffer, pio handshake
// R12 - dma write moves 1 to 256 sectors; a count of zero means 256
// R13 - dma write starts at the addressed sector and walks consecutive sectors
// R14 - dma write raises busy on acceptance; drq and busy release are optional
// R15 - dmarq is held while the drive can take data
// R16 - host asserts dmack and strobes write once per 16-bit word
// R17 - dma write interrupts only at the end or on an unrecoverable error
// R18 - after a good dma write the address registers hold the last sector
// R19 - on error the write stops and the failing sector address is kept
// R20 - dma write is aborted while 8-bit transfer mode is enabled
// R21 - lba bits 27-24 head nibble, 23-16 high, 15-8 mid, 7-0 low
// R22 - write multiple while multi-sector mode is disabled is aborted
// R23 - any nonzero count other than the supported one leaves multi-sector disabled
package acm_pkg;
    // task file addresses
    localparam logic [2:0] TF_DATA = 3'h0;
    localparam logic [2:0] TF_FEAT = 3'h1;
    localparam logic [2:0] TF_CNT = 3'h2;
    localparam logic [2:0] TF_LOW = 3'h3;
    localparam logic [2:0] TF_MID = 3'h4;
    localparam logic [2:0] TF_HIGH = 3'h5;
    localparam logic [2:0] TF_HEAD = 3'h6;
    localparam logic [2:0] TF_CMD = 3'h7;
    // opcodes
    localparam logic [7:0] OP_SET_MULT = 8'hc6;
    localparam logic [7:0] OP_STBY_A = 8'h96;
    localparam logic [7:0] OP_STBY_B = 8'he2;
    localparam logic [7:0] OP_STBYI_A = 8'h94;
    localparam logic [7:0] OP_STBYI_B = 8'he0;
    localparam logic [7:0] OP_TRANSLATE = 8'h87;
    localparam logic [7:0] OP_WR_BUF = 8'he8;
    localparam logic [7:0] OP_WR_DMA = 8'hca;
    localparam logic [7:0] OP_WR_MULT = 8'hc5;
    localparam logic [7:0] OP_SET_FEAT = 8'hef;
    localparam logic [7:0] FEAT_8BIT_ON = 8'h01;
    localparam logic [7:0] FEAT_8BIT_OFF = 8'h81;
    // status and error bit positions
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ER_ABRT = 2;
    // sector geometry: 256 words of 16 bits is 512 bytes
    localparam logic [7:0] WORD_LAST = 8'hff;
    localparam logic [8:0] SECS_MAX = 9'h100;
    localparam logic [8:0] SECS_ONE = 9'h001;
    localparam logic [15:0] ID_W82_VALUE = 16'h0001;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_EXEC = 3'b001,
        ST_XFER = 3'b010,
        ST_COMMIT = 3'b011,
        ST_DONE = 3'b100
    } acm_state_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [15:0] wdata;
    } acm_tf_req_t;
    typedef struct packed {
        logic valid;
        logic [27:0] lba;
    } acm_sec_req_t;
endpackage : acm_pkg

// ---- rtl/acm_sync.sv ----
// two-stage synchroniser for pins that arrive from the host
module acm_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // pins in, synchronised copy out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout_q
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second one
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= RST_VAL;
            dout_q <= RST_VAL;
        end else begin
            meta_q <= din;
            dout_q <= meta_q;
        end
    end
endmodule : acm_sync

// ---- rtl/acm_core.sv ----
// ata command handler: set multiple, standby, translate, write buffer, write dma
module acm_core #(
    parameter logic [7:0] BLK_SUPPORTED = 8'h01
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // task file access from the host interface logic
    input wire acm_pkg::acm_tf_req_t tf_req,
    output logic [7:0] tf_rdata_q,
    output logic intrq_q,
    // dma pins
    input wire logic dmack_n,
    input wire logic iowr_n,
    input wire logic [15:0] dd,
    output logic dmarq_q,
    // flash side
    output acm_pkg::acm_sec_req_t sec_req_q,
    input wire logic fl_ack,
    input wire logic fl_err,
    input wire logic [7:0] fl_raddr,
    output logic [15:0] fl_rdata_q,
    // status
    output logic sleep_q,
    output logic [15:0] id_word82_q
);
    acm_pkg::acm_state_t state_q;
    logic [7:0] cmd_q, feat_q, cnt_q, low_q, mid_q, high_q, head_q, block_q;
    logic bsy_q, drq_q, err_q, abrt_q, multi_en_q, eightbit_q;
    logic dma_q, commit_q, iowr_prev_q;
    logic [8:0] secs_q;
    logic [7:0] widx_q;
    logic [15:0] sbuf [0:255];
    logic [17:0] pin_s;
    logic dmack_s, iowr_s;
    logic [15:0] dd_s;
    logic cmd_wr, reg_wr, iowr_rise, take_dma, take_pio, take, last_word;
    logic [15:0] word;
    logic [8:0] sec_total;
    logic [27:0] lba, lba_inc;
    logic [7:0] stat_byte, err_byte;

    // host pins cross into the drive clock before anything looks at them
    acm_sync #(.W(18), .RST_VAL(18'h30000)) u_pin_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din({dmack_n, iowr_n, dd}),
        .dout_q(pin_s)
    );
    assign dmack_s = pin_s[17];
    assign iowr_s = pin_s[16];
    assign dd_s = pin_s[15:0];

    // strobe decode; a dma word is taken on the trailing edge of the write strobe
    assign cmd_wr = tf_req.wr && tf_req.addr == acm_pkg::TF_CMD && state_q == acm_pkg::ST_IDLE;
    assign reg_wr = tf_req.wr && !bsy_q && state_q == acm_pkg::ST_IDLE;
    assign iowr_rise = iowr_s && !iowr_prev_q;
    assign take_dma = dma_q && dmarq_q && iowr_rise && !dmack_s; // see R16
    assign take_pio = !dma_q && drq_q && tf_req.wr && tf_req.addr == acm_pkg::TF_DATA;
    assign take = state_q == acm_pkg::ST_XFER && (take_dma || take_pio);
    assign last_word = widx_q == acm_pkg::WORD_LAST; // see R11
    assign word = dma_q ? dd_s : tf_req.wdata;
    // zero in the count register asks for the full 256 sectors
    assign sec_total = (cnt_q == 8'h00) ? acm_pkg::SECS_MAX : {1'b0, cnt_q}; // see R12
    assign lba = {head_q[3:0], high_q, mid_q, low_q}; // see R21
    assign lba_inc = lba + 28'h0000001;

    // status and error bytes as the host reads them
    always_comb begin
        stat_byte = 8'h00;
        stat_byte[acm_pkg::ST_BSY] = bsy_q;
        stat_byte[acm_pkg::ST_DRDY] = !bsy_q;
        stat_byte[acm_pkg::ST_DRQ] = drq_q;
        stat_byte[acm_pkg::ST_ERR] = err_q;
        err_byte = 8'h00;
        err_byte[acm_pkg::ER_ABRT] = abrt_q;
    end

    // command sequencer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= acm_pkg::ST_IDLE;
            cmd_q <= 8'h00;
            bsy_q <= 1'b0;
            drq_q <= 1'b0;
            err_q <= 1'b0;
            abrt_q <= 1'b0;
            multi_en_q <= 1'b0; // see R5
            block_q <= 8'h00;
            eightbit_q <= 1'b0;
            sleep_q <= 1'b0;
            dma_q <= 1'b0;
            commit_q <= 1'b0;
            secs_q <= 9'h000;
        end else begin
            case (state_q)
                acm_pkg::ST_IDLE: begin
                    if (cmd_wr) begin
                        cmd_q <= tf_req.wdata[7:0];
                        bsy_q <= 1'b1; // see R1
                        err_q <= 1'b0;
                        abrt_q <= 1'b0;
                        sleep_q <= 1'b0; // see R9
                        state_q <= acm_pkg::ST_EXEC;
                    end
                end
                acm_pkg::ST_EXEC: begin
                    state_q <= acm_pkg::ST_DONE;
                    case (cmd_q)
                        acm_pkg::OP_SET_MULT: begin
                            if (cnt_q == 8'h00) begin
                                multi_en_q <= 1'b0; // see R4
                            end else if (cnt_q == BLK_SUPPORTED) begin
                                multi_en_q <= 1'b1; // see R2
                                block_q <= cnt_q;
                            end else begin
                                // anything else is unsupported
                                err_q <= 1'b1; // see R3
                                abrt_q <= 1'b1;
                                multi_en_q <= 1'b0; // see R23
                            end
                        end
                        acm_pkg::OP_STBY_A, acm_pkg::OP_STBY_B: begin
                            sleep_q <= 1'b1; // see R7
                        end
                        acm_pkg::OP_STBYI_A, acm_pkg::OP_STBYI_B: begin
                            sleep_q <= 1'b1; // see R8
                        end
                        acm_pkg::OP_TRANSLATE: begin
                            // count register cleared in the register block
                        end
                        acm_pkg::OP_SET_FEAT: begin
                            if (feat_q == acm_pkg::FEAT_8BIT_ON) begin
                                eightbit_q <= 1'b1;
                            end else if (feat_q == acm_pkg::FEAT_8BIT_OFF) begin
                                eightbit_q <= 1'b0;
                            end
                        end
                        acm_pkg::OP_WR_BUF: begin
                            // one sector into the buffer, never committed
                            state_q <= acm_pkg::ST_XFER;
                            dma_q <= 1'b0;
                            commit_q <= 1'b0;
                            secs_q <= acm_pkg::SECS_ONE;
                            drq_q <= 1'b1; // see R11
                            bsy_q <= 1'b0;
                        end
                        acm_pkg::OP_WR_MULT: begin
                            if (!multi_en_q) begin
                                err_q <= 1'b1; // see R22
                                abrt_q <= 1'b1;
                            end else begin
                                state_q <= acm_pkg::ST_XFER;
                                dma_q <= 1'b0;
                                commit_q <= 1'b1;
                                secs_q <= sec_total;
                                drq_q <= 1'b1;
                                bsy_q <= 1'b0;
                            end
                        end
                        acm_pkg::OP_WR_DMA: begin
                            if (eightbit_q) begin
                                err_q <= 1'b1; // see R20
                                abrt_q <= 1'b1;
                            end else begin
                                // busy stays up for the whole dma burst
                                state_q <= acm_pkg::ST_XFER; // see R14
                                dma_q <= 1'b1;
                                commit_q <= 1'b1;
                                secs_q <= sec_total; // see R12
                            end
                        end
                        default: begin
                            err_q <= 1'b1;
                            abrt_q <= 1'b1;
                        end
                    endcase
                end
                acm_pkg::ST_XFER: begin
                    if (take && last_word) begin
                        drq_q <= 1'b0;
                        bsy_q <= 1'b1;
                        state_q <= commit_q ? acm_pkg::ST_COMMIT : acm_pkg::ST_DONE;
                    end
                end
                acm_pkg::ST_COMMIT: begin
                    if (fl_ack) begin
                        if (fl_err) begin
                            err_q <= 1'b1; // see R19
                            abrt_q <= 1'b1;
                            state_q <= acm_pkg::ST_DONE;
                        end else if (secs_q == acm_pkg::SECS_ONE) begin
                            state_q <= acm_pkg::ST_DONE;
                        end else begin
                            secs_q <= secs_q - acm_pkg::SECS_ONE;
                            state_q <= acm_pkg::ST_XFER; // see R13
                            drq_q <= !dma_q;
                            bsy_q <= dma_q;
                        end
                    end
                end
                acm_pkg::ST_DONE: begin
                    bsy_q <= 1'b0; // see R7
                    state_q <= acm_pkg::ST_IDLE;
                end
                default: state_q <= acm_pkg::ST_IDLE;
            endcase
        end
    end

    // task file registers; the engine updates win over host writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            feat_q <= 8'h00;
            cnt_q <= 8'h00;
            low_q <= 8'h00;
            mid_q <= 8'h00;
            high_q <= 8'h00;
            head_q <= 8'h00;
        end else if (state_q == acm_pkg::ST_EXEC && cmd_q == acm_pkg::OP_TRANSLATE) begin
            cnt_q <= 8'h00; // see R10
        end else if (state_q == acm_pkg::ST_COMMIT && fl_ack && !fl_err) begin
            cnt_q <= cnt_q - 8'h01;
            // the last good sector stays addressed at the end
            if (secs_q != acm_pkg::SECS_ONE) begin
                {head_q[3:0], high_q, mid_q, low_q} <= lba_inc; // see R18
            end
        end else if (reg_wr) begin
            case (tf_req.addr)
                acm_pkg::TF_FEAT: feat_q <= tf_req.wdata[7:0];
                acm_pkg::TF_CNT: cnt_q <= tf_req.wdata[7:0];
                acm_pkg::TF_LOW: low_q <= tf_req.wdata[7:0];
                acm_pkg::TF_MID: mid_q <= tf_req.wdata[7:0];
                acm_pkg::TF_HIGH: high_q <= tf_req.wdata[7:0];
                acm_pkg::TF_HEAD: head_q <= tf_req.wdata[7:0];
                default: ;
            endcase
        end
    end

    // register read, one cycle behind the read strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tf_rdata_q <= 8'h00;
        end else if (tf_req.rd) begin
            case (tf_req.addr)
                acm_pkg::TF_FEAT: tf_rdata_q <= err_byte;
                acm_pkg::TF_CNT: tf_rdata_q <= cnt_q;
                acm_pkg::TF_LOW: tf_rdata_q <= low_q;
                acm_pkg::TF_MID: tf_rdata_q <= mid_q;
                acm_pkg::TF_HIGH: tf_rdata_q <= high_q;
                acm_pkg::TF_HEAD: tf_rdata_q <= head_q;
                acm_pkg::TF_CMD: tf_rdata_q <= stat_byte;
                default: tf_rdata_q <= 8'h00;
            endcase
        end
    end

    // interrupt: raised only on completion; a status read or new command clears it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            intrq_q <= 1'b0;
        end else if (state_q == acm_pkg::ST_DONE) begin
            intrq_q <= 1'b1; // see R17
        end else if (cmd_wr || (tf_req.rd && tf_req.addr == acm_pkg::TF_CMD)) begin
            intrq_q <= 1'b0;
        end
    end

    // dmarq drops on the last word so a late strobe cannot overrun the buffer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dmarq_q <= 1'b0;
            iowr_prev_q <= 1'b1;
        end else begin
            dmarq_q <= state_q == acm_pkg::ST_XFER && dma_q && !(take && last_word); // see R15
            iowr_prev_q <= iowr_s;
        end
    end

    // word index into the sector buffer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            widx_q <= 8'h00;
        end else if (state_q != acm_pkg::ST_XFER) begin
            widx_q <= 8'h00;
        end else if (take) begin
            widx_q <= widx_q + 8'h01;
        end
    end

    // sector buffer, overwritten by each transfer
    always_ff @(posedge clk) begin
        if (take) begin
            sbuf[widx_q] <= word; // see R11
        end
    end

    // flash read port and sector hand-off
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fl_rdata_q <= 16'h0000;
            sec_req_q <= '0;
            id_word82_q <= acm_pkg::ID_W82_VALUE; // see R6
        end else begin
            fl_rdata_q <= sbuf[fl_raddr];
            if (state_q == acm_pkg::ST_XFER && take && last_word && commit_q) begin
                sec_req_q.valid <= 1'b1;
                sec_req_q.lba <= lba; // see R13
            end else if (fl_ack) begin
                sec_req_q.valid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_cmd_busy: assert property (cmd_wr |=> bsy_q) // see R1
        else $error("command did not raise busy");
    chk_zero_off: assert property (state_q == acm_pkg::ST_EXEC // see R4
        && cmd_q == acm_pkg::OP_SET_MULT && cnt_q == 8'h00 |=> !multi_en_q && !abrt_q)
        else $error("zero block count left multiple enabled");
    chk_good_on: assert property (state_q == acm_pkg::ST_EXEC // see R2
        && cmd_q == acm_pkg::OP_SET_MULT && cnt_q == BLK_SUPPORTED
        |=> multi_en_q && block_q == BLK_SUPPORTED)
        else $error("supported block count not taken");
    chk_bad_abort: assert property (state_q == acm_pkg::ST_EXEC // see R3
        && cmd_q == acm_pkg::OP_SET_MULT && cnt_q != 8'h00 && cnt_q != BLK_SUPPORTED
        |=> abrt_q && !multi_en_q)
        else $error("bad block count not aborted");
    chk_standby_irq: assert property (state_q == acm_pkg::ST_EXEC // see R7 R8
        && (cmd_q == acm_pkg::OP_STBY_A || cmd_q == acm_pkg::OP_STBY_B
        || cmd_q == acm_pkg::OP_STBYI_A || cmd_q == acm_pkg::OP_STBYI_B)
        |=> sleep_q ##1 (!bsy_q && intrq_q))
        else $error("standby did not sleep and interrupt");
    chk_wake_cmd: assert property (cmd_wr && sleep_q |=> !sleep_q) // see R9
        else $error("new command did not wake the drive");
    chk_translate_zero: assert property (state_q == acm_pkg::ST_EXEC // see R10
        && cmd_q == acm_pkg::OP_TRANSLATE |=> cnt_q == 8'h00 ##1 intrq_q)
        else $error("translate did not return zero");
    chk_dmarq_xfer: assert property (dmarq_q // see R15
        |-> $past(state_q) == acm_pkg::ST_XFER && dma_q)
        else $error("dmarq outside a dma transfer");
    chk_irq_end: assert property ($rose(intrq_q) |-> $past(state_q) == acm_pkg::ST_DONE) // see R17
        else $error("interrupt raised mid transfer");
    chk_8bit_abort: assert property (state_q == acm_pkg::ST_EXEC // see R20
        && cmd_q == acm_pkg::OP_WR_DMA && eightbit_q |=> abrt_q && state_q == acm_pkg::ST_DONE)
        else $error("dma write accepted in 8-bit mode");
    chk_err_lba: assert property (state_q == acm_pkg::ST_COMMIT && fl_ack && fl_err // see R19
        |=> $stable(lba) && err_q)
        else $error("failing sector address lost");
    chk_mult_reject: assert property (state_q == acm_pkg::ST_EXEC // see R22
        && cmd_q == acm_pkg::OP_WR_MULT && !multi_en_q |=> abrt_q && !drq_q)
        else $error("write multiple accepted while disabled");

    cov_dma_done: cover property (state_q == acm_pkg::ST_COMMIT && fl_ack && !fl_err
        && secs_q == acm_pkg::SECS_ONE && dma_q);
    cov_dma_err: cover property (state_q == acm_pkg::ST_COMMIT && fl_ack && fl_err && dma_q);
    cov_buf_fill: cover property (take_pio && last_word && !commit_q);
    cov_set_mult: cover property (state_q == acm_pkg::ST_EXEC && cmd_q == acm_pkg::OP_SET_MULT
        && cnt_q == BLK_SUPPORTED);
endmodule : acm_core

// ---- testbench/acm_host.sv ----
// host model: task-file cycles and dma words
module acm_host (
    // clock
    input wire logic clk,
    // task file and dma pins
    output acm_pkg::acm_tf_req_t tf_req,
    output logic dmack_n,
    output logic iowr_n,
    output logic [15:0] dd,
    input wire logic [7:0] tf_rdata_q
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        tf_req = '0;
        dmack_n = 1'b1;
        iowr_n = 1'b1;
        dd = 16'h0000;
    end
    // one-cycle write; next call waits an edge, so no double drive
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        tf_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        tf_req.wr <= 1'b0;
    endtask : wr
    // read data lands on the same edge that sees the pulse
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        tf_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        tf_req.rd <= 1'b0;
        #1 d = tf_rdata_q;
    endtask : rd
    // sector address split over four registers
    task automatic lba(input logic [27:0] s);
        wr(acm_pkg::TF_HEAD, {12'h00e, s[27:24]});
        wr(acm_pkg::TF_HIGH, {8'h00, s[23:16]});
        wr(acm_pkg::TF_MID, {8'h00, s[15:8]});
        wr(acm_pkg::TF_LOW, {8'h00, s[7:0]});
    endtask : lba
    // strobe low and high 4 clocks each, the synchroniser needs 2
    task automatic dword(input logic [15:0] w);
        @(posedge clk);
        dmack_n <= 1'b0;
        dd <= w;
        iowr_n <= 1'b0;
        repeat (4) @(posedge clk);
        iowr_n <= 1'b1;
        repeat (4) @(posedge clk);
        dd <= ~w;  // hold time over, stale word not kept
    endtask : dword
endmodule : acm_host

// ---- testbench/tb_acm_core.sv ----
// self-checking bench for the ata command handler
module tb_acm_core;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, dmack_n, iowr_n, intrq_q, dmarq_q, fl_ack, fl_err, sleep_q;
    logic [15:0] dd, fl_rdata_q, id_word82_q;
    logic [15:0] buf_q[256];
    logic [7:0] tf_rdata_q, fl_raddr, st, v;
    logic [7:0] ops[4] = '{acm_pkg::OP_STBY_A, acm_pkg::OP_STBY_B,
        acm_pkg::OP_STBYI_A, acm_pkg::OP_STBYI_B};
    logic [27:0] exp_lba, s, a;
    logic [31:0] seed = 32'h0c94;
    int fails = 0, n_tests = 0, err_at = -1, nsec = 0;
    acm_pkg::acm_tf_req_t tf_req;
    acm_pkg::acm_sec_req_t sec_req_q;
    acm_core dut (.clk(clk), .sys_rst(sys_rst), .tf_req(tf_req), .tf_rdata_q(tf_rdata_q),
        .intrq_q(intrq_q), .dmack_n(dmack_n), .iowr_n(iowr_n), .dd(dd), .dmarq_q(dmarq_q),
        .sec_req_q(sec_req_q), .fl_ack(fl_ack), .fl_err(fl_err), .fl_raddr(fl_raddr),
        .fl_rdata_q(fl_rdata_q), .sleep_q(sleep_q), .id_word82_q(id_word82_q));
    acm_host host (.clk(clk), .tf_req(tf_req), .dmack_n(dmack_n), .iowr_n(iowr_n),
        .dd(dd), .tf_rdata_q(tf_rdata_q));
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
        return seed;
    endfunction : rnd
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    // bounded wait on dma request or interrupt
    task automatic hold(input bit dma);
        int i;
        for (i = 0; i < 9999; i++) begin
            if ((dma ? dmarq_q : intrq_q) === 1'b1) break;
            @(posedge clk);
        end
        if (i == 9999) begin
            fails++;
            conclude();
        end
    endtask : hold
    task automatic cmd(input logic [7:0] c, input logic [7:0] op);
        host.wr(acm_pkg::TF_CNT, {8'h00, c});
        host.wr(acm_pkg::TF_CMD, {8'h00, op});
    endtask : cmd
    // completion: interrupt, then error flag and abort bit
    task automatic fin(input logic e);
        hold(1'b0);
        host.rd(acm_pkg::TF_CMD, st);
        check(st[acm_pkg::ST_ERR], e);
        host.rd(acm_pkg::TF_FEAT, v);
        check(v[acm_pkg::ER_ABRT], e);
    endtask : fin
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // flash side acks each sector after a random stall
    initial begin
        fl_ack = 1'b0;
        fl_err = 1'b0;
        forever begin
            @(posedge clk iff sec_req_q.valid === 1'b1);
            check(sec_req_q.lba, exp_lba);
            check(intrq_q, 1'b0);
            repeat (rnd() % 4) @(posedge clk);
            fl_err <= (nsec == err_at);
            fl_ack <= 1'b1;
            @(posedge clk);
            fl_ack <= 1'b0;
            fl_err <= 1'b0;
            nsec++;
            exp_lba++;
        end
    end
    initial begin
        sys_rst = 1'b1;
        fl_raddr = 8'h00;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        check(id_word82_q[0], 1'b1);
        repeat (3) @(posedge clk);
        cmd(8'h01, acm_pkg::OP_WR_MULT);
        fin(1'b1);
        cmd(8'h00, acm_pkg::OP_SET_MULT);
        fin(1'b0);
        cmd(8'h01, acm_pkg::OP_WR_MULT);
        fin(1'b1);
        cmd(8'(rnd()) | 8'h02, acm_pkg::OP_SET_MULT);
        fin(1'b1);
        cmd(8'h01, acm_pkg::OP_WR_MULT);
        fin(1'b1);
        s = 28'(rnd());
        host.lba(s);
        exp_lba = s;
        cmd(8'h01, acm_pkg::OP_SET_MULT);
        fin(1'b0);
        cmd(8'h01, acm_pkg::OP_WR_MULT);
        repeat (4) @(posedge clk);
        for (int i = 0; i < 256; i++) host.wr(acm_pkg::TF_DATA, 16'(rnd()));
        fin(1'b0);
        foreach (ops[i]) begin
            cmd(8'h00, ops[i]);
            fin(1'b0);
            check(sleep_q, 1'b1);
            cmd(8'(rnd()), acm_pkg::OP_TRANSLATE);
            fin(1'b0);
            check(sleep_q, 1'b0);
            host.rd(acm_pkg::TF_CNT, v);
            check(v, 8'h00);
        end
        cmd(8'h00, acm_pkg::OP_WR_BUF);
        repeat (4) @(posedge clk);
        for (int i = 0; i < 256; i++) begin
            buf_q[i] = 16'(rnd());
            host.wr(acm_pkg::TF_DATA, buf_q[i]);
        end
        fin(1'b0);
        for (int i = 0; i < 256; i++) begin
            fl_raddr <= 8'(i);
            repeat (2) @(posedge clk);
            check(fl_rdata_q, buf_q[i]);
        end
        host.wr(acm_pkg::TF_FEAT, {8'h00, acm_pkg::FEAT_8BIT_ON});
        cmd(8'h00, acm_pkg::OP_SET_FEAT);
        fin(1'b0);
        cmd(8'h01, acm_pkg::OP_WR_DMA);
        fin(1'b1);
        host.wr(acm_pkg::TF_FEAT, {8'h00, acm_pkg::FEAT_8BIT_OFF});
        cmd(8'h00, acm_pkg::OP_SET_FEAT);
        fin(1'b0);
        // two sectors clean, then count zero failing on its second sector
        for (int k = 0; k < 2; k++) begin
            s = 28'(rnd());
            host.lba(s);
            exp_lba = s;
            nsec = 0;
            err_at = k ? 1 : -1;
            cmd(k ? 8'h00 : 8'h02, acm_pkg::OP_WR_DMA);
            host.rd(acm_pkg::TF_CMD, st);
            check(st[acm_pkg::ST_BSY] | st[acm_pkg::ST_DRQ], 1'b1);
            for (int j = 0; j < 512; j++) begin
                hold(1'b1);
                host.dword(16'(rnd()));
            end
            fin(k[0]);
            host.rd(acm_pkg::TF_HEAD, v);
            a[27:24] = v[3:0];
            host.rd(acm_pkg::TF_HIGH, a[23:16]);
            host.rd(acm_pkg::TF_MID, a[15:8]);
            host.rd(acm_pkg::TF_LOW, a[7:0]);
            check(a, 28'(s + 28'h1));
        end
        conclude();
    end
endmodule : tb_acm_core
